// File: rtl/dbgid_cfg.svh
// Purpose: Offsets, field positions and fixed values of the debug id block
// Assumes: 12-bit byte offsets within the debug component page
// Notes:   Identity codes are module parameters, not macros
`ifndef DBGID_CFG_SVH
`define DBGID_CFG_SVH

// Register byte offsets
`define DBGID_OFF_RSV_CTRL  12'h090
`define DBGID_OFF_DEVFEAT1  12'hfc4
`define DBGID_OFF_DEVFEAT0  12'hfc8
`define DBGID_OFF_PID4      12'hfd0
`define DBGID_OFF_PID5      12'hfd4
`define DBGID_OFF_PID6      12'hfd8
`define DBGID_OFF_PID7      12'hfdc
`define DBGID_OFF_PID0      12'hfe0
`define DBGID_OFF_PID1      12'hfe4
`define DBGID_OFF_PID2      12'hfe8
`define DBGID_OFF_PID3      12'hfec
`define DBGID_OFF_CID0      12'hff0
`define DBGID_OFF_CID1      12'hff4
`define DBGID_OFF_CID2      12'hff8
`define DBGID_OFF_CID3      12'hffc

// Reserve control bit positions
`define DBGID_BIT_CLR_PIPE  3
`define DBGID_BIT_CLR_ERR   2

// Fixed identification fields
`define DBGID_PREAMBLE_0    8'h0d
`define DBGID_CLASS_DEBUG   4'h9
`define DBGID_PREAMBLE_1    4'h0
`define DBGID_PREAMBLE_2    8'h05
`define DBGID_PREAMBLE_3    8'hb1
`define DBGID_AUX_REGS      4'h0
`define DBGID_SIZE_LOG2     4'h0
`define DBGID_STD_CODE      1'b1

// Response latency in clock cycles
`define DBGID_RSP_LATENCY   1

`endif

// File: rtl/dbgid_pkg.sv
// Purpose: Types shared by the debug id block and its users
// Assumes: Constants live in dbgid_cfg.svh
// Notes:   Request and response are one word wide
package dbgid_pkg;

    // One register access request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } dbgid_req_t;

    // Answer to one access
    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } dbgid_rsp_t;

    // Core power and lock state
    typedef struct packed {
        logic powered_off;
        logic double_lock_state;
        logic os_lock_state;
        logic software_lock_state;
        logic in_debug;
    } dbgid_core_t;

    // Sticky debug status flags
    typedef struct packed {
        logic pipeline_advanced_flag;
        logic transmit_underrun_flag;
        logic receive_overrun_flag;
        logic error_flag;
        logic instr_transfer_overrun_flag;
    } dbgid_flags_t;

endpackage

// File: rtl/dbgid_regs.sv
// Purpose: Debug identification words and reserve control clear logic
// Assumes: Requests and core state come from logic on clk
// Notes:   Port 0 is the external debug side, port 1 the memory-mapped side
// Function
// - Component id 1 reads class 0x9, preamble nibble 0, zero above.
// - Component id 2 reads 0x05 in the low byte, zero above.
// - Component id 3 reads 0xb1 in the low byte, zero above.
// - Feature word 0 reports no auxiliary registers in bits 27:24; rest zero.
// - Feature word 1 reads all zero.
// - Peripheral id 0 holds low byte of part number.
// - Peripheral id 1 holds designer code low nibble and part top nibble.
// - Peripheral id 2 holds major revision, bit 3 one, designer high bits.
// - Peripheral id 3 holds minor revision and customer-modified fields.
// - Peripheral id 4 holds size zero and continuation code.
// - Peripheral ids 5 to 7 read all zero.
// - Writing one to bit 3 clears the pipeline advanced flag.
// - Writing one to bit 2 clears underrun, overrun and error flags.
// - Same write clears instruction overrun flag only in debug state.
// - Writing zero to a clear bit does nothing; other bits reserved.
// - Error when off, double locked or OS locked; ignore writes under software lock.
// - Reserve control decoded at 0x090 on both interfaces.
// - Reserve control lives in the core power domain.
// - Identification words decoded at their fixed external offsets.
// - Component id 0 reads 0x0d in the low byte, zero above.
`timescale 1ns/1ps
`default_nettype none
`include "dbgid_cfg.svh"

module dbgid_regs #(
    parameter logic [11:0] PART_NUM     = 12'h5a3, // Arbitrary value
    parameter logic [6:0]  DESIGNER_ID  = 7'h35,   // Arbitrary value
    parameter logic [3:0]  CONT_CODE    = 4'h7,    // Arbitrary value
    parameter logic [3:0]  MAJOR_REV    = 4'h1,    // Arbitrary value
    parameter logic [3:0]  MINOR_REV    = 4'h0,
    parameter logic [3:0]  CUST_MOD     = 4'h0
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    ce,
    input  wire dbgid_pkg::dbgid_req_t   ext_req,
    input  wire dbgid_pkg::dbgid_req_t   int_req,
    input  wire dbgid_pkg::dbgid_core_t  core,
    input  wire dbgid_pkg::dbgid_flags_t flag_set,
    output var  dbgid_pkg::dbgid_rsp_t   ext_rsp,
    output var  dbgid_pkg::dbgid_rsp_t   int_rsp,
    output var  dbgid_pkg::dbgid_flags_t flags
);
    import dbgid_pkg::*;

    localparam int NPORT = 2;
    localparam int EXT   = 0;

    // Reserve control hit on either interface
    function automatic logic rc_hit(input logic [11:0] addr);
        rc_hit = (addr == `DBGID_OFF_RSV_CTRL);
    endfunction

    // Read data of one interface
    function automatic logic [31:0] read_word(
        input logic [11:0] addr,
        input logic        ext
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        if (ext) begin
            unique case (addr)
                `DBGID_OFF_CID0: begin
                    w[7:0] = `DBGID_PREAMBLE_0;
                end
                `DBGID_OFF_CID1: begin
                    w[7:4] = `DBGID_CLASS_DEBUG;
                    w[3:0] = `DBGID_PREAMBLE_1;
                end
                `DBGID_OFF_CID2: begin
                    w[7:0] = `DBGID_PREAMBLE_2;
                end
                `DBGID_OFF_CID3: begin
                    w[7:0] = `DBGID_PREAMBLE_3;
                end
                `DBGID_OFF_DEVFEAT0: begin
                    w[27:24] = `DBGID_AUX_REGS;
                end
                `DBGID_OFF_DEVFEAT1: begin
                    w = 32'h0000_0000;
                end
                `DBGID_OFF_PID0: begin
                    w[7:0] = PART_NUM[7:0];
                end
                `DBGID_OFF_PID1: begin
                    w[7:4] = DESIGNER_ID[3:0];
                    w[3:0] = PART_NUM[11:8];
                end
                `DBGID_OFF_PID2: begin
                    w[7:4] = MAJOR_REV;
                    w[3]   = `DBGID_STD_CODE;
                    w[2:0] = DESIGNER_ID[6:4];
                end
                `DBGID_OFF_PID3: begin
                    w[7:4] = MINOR_REV;
                    w[3:0] = CUST_MOD;
                end
                `DBGID_OFF_PID4: begin
                    w[7:4] = `DBGID_SIZE_LOG2;
                    w[3:0] = CONT_CODE;
                end
                `DBGID_OFF_PID5, `DBGID_OFF_PID6, `DBGID_OFF_PID7: begin
                    w = 32'h0000_0000;
                end
                default: begin
                    w = 32'h0000_0000;
                end
            endcase
        end
        read_word = w;
    endfunction

    dbgid_req_t   req [NPORT];
    dbgid_rsp_t   rsp_q [NPORT];
    dbgid_rsp_t   rsp_d [NPORT];
    dbgid_flags_t flags_q;
    dbgid_flags_t flags_d;
    logic [NPORT-1:0] clr_pipe_p;
    logic [NPORT-1:0] clr_err_p;

    assign req[0] = ext_req;
    assign req[1] = int_req;

    // Power-off and hard locks refuse the control register
    wire lock_err = core.powered_off | core.double_lock_state
                  | core.os_lock_state;
    wire soft_lock = core.software_lock_state;

    // Per-interface decode and answer
    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            wire hit = req[p].valid & rc_hit(req[p].addr);
            wire wr_ok = hit & req[p].write & ~lock_err & ~soft_lock;
            assign clr_pipe_p[p] = wr_ok
                & req[p].wdata[`DBGID_BIT_CLR_PIPE];
            assign clr_err_p[p] = wr_ok
                & req[p].wdata[`DBGID_BIT_CLR_ERR];
            always_comb begin
                rsp_d[p].ack   = req[p].valid;
                rsp_d[p].err   = hit & lock_err;
                rsp_d[p].rdata = (req[p].valid & ~req[p].write)
                    ? read_word(req[p].addr, (p == EXT)) : 32'h0000_0000;
            end
            // Answer register, one cycle after the request
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    rsp_q[p] <= '0;
                end else if (ce) begin
                    rsp_q[p] <= rsp_d[p];
                end
            end
        end
    endgenerate

    // Clears from either interface combine
    wire clr_pipe = |clr_pipe_p;
    wire clr_err  = |clr_err_p;
    wire clr_ito  = clr_err & core.in_debug;

    // Sticky flags, set wins over clear
    always_comb begin
        flags_d.pipeline_advanced_flag = flag_set.pipeline_advanced_flag
            | (flags_q.pipeline_advanced_flag & ~clr_pipe);
        flags_d.transmit_underrun_flag = flag_set.transmit_underrun_flag
            | (flags_q.transmit_underrun_flag & ~clr_err);
        flags_d.receive_overrun_flag = flag_set.receive_overrun_flag
            | (flags_q.receive_overrun_flag & ~clr_err);
        flags_d.error_flag = flag_set.error_flag
            | (flags_q.error_flag & ~clr_err);
        flags_d.instr_transfer_overrun_flag =
            flag_set.instr_transfer_overrun_flag
            | (flags_q.instr_transfer_overrun_flag & ~clr_ito);
    end

    // Flag register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_q <= '0;
        end else if (ce) begin
            flags_q <= flags_d;
        end
    end

    // Outputs straight from the registers
    assign ext_rsp = rsp_q[0];
    assign int_rsp = rsp_q[1];
    assign flags   = flags_q;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    wire ext_rd = ce & ext_req.valid & ~ext_req.write;
    wire ext_rcw = ce & ext_req.valid & ext_req.write
                 & rc_hit(ext_req.addr);
    wire no_set = (flag_set == '0);

    // Memory-mapped side qualifiers
    wire int_rd  = ce & int_req.valid & ~int_req.write;
    wire int_rcw = ce & int_req.valid & int_req.write
                 & rc_hit(int_req.addr);

    AST_CID1: assert property (
        ext_rd && ext_req.addr == `DBGID_OFF_CID1
        |=> ext_rsp.ack && ext_rsp.rdata == 32'h0000_0090)
        else $error("component id 1 wrong");

    AST_CID2: assert property (
        ext_rd && ext_req.addr == `DBGID_OFF_CID2
        |=> ext_rsp.rdata == 32'h0000_0005)
        else $error("component id 2 wrong");

    AST_CID3: assert property (
        ext_rd && ext_req.addr == `DBGID_OFF_CID3
        |=> ext_rsp.rdata == 32'h0000_00b1)
        else $error("component id 3 wrong");

    AST_CID0: assert property (
        ext_rd && ext_req.addr == `DBGID_OFF_CID0
        |=> ext_rsp.rdata == 32'h0000_000d && !ext_rsp.err)
        else $error("component id 0 wrong");

    AST_FEAT: assert property (
        ext_rd && (ext_req.addr == `DBGID_OFF_DEVFEAT0
                   || ext_req.addr == `DBGID_OFF_DEVFEAT1)
        |=> ext_rsp.rdata == 32'h0000_0000)
        else $error("feature word not zero");

    AST_PID2: assert property (
        ext_rd && ext_req.addr == `DBGID_OFF_PID2
        |=> ext_rsp.rdata[3] && ext_rsp.rdata[31:8] == 24'h00_0000)
        else $error("peripheral id 2 code flag wrong");

    AST_PID4: assert property (
        ext_rd && ext_req.addr == `DBGID_OFF_PID4
        |=> ext_rsp.rdata[31:4] == 28'h000_0000)
        else $error("peripheral id 4 size wrong");

    AST_PID_HI: assert property (
        ext_rd && ext_req.addr >= `DBGID_OFF_PID5
        && ext_req.addr <= `DBGID_OFF_PID7
        |=> ext_rsp.rdata == 32'h0000_0000)
        else $error("peripheral id 5-7 not zero");

    AST_CLR_PIPE: assert property (
        ext_rcw && !lock_err && !soft_lock
        && ext_req.wdata[3] && !flag_set.pipeline_advanced_flag
        |=> !flags.pipeline_advanced_flag)
        else $error("pipeline flag not cleared");

    AST_CLR_ERR: assert property (
        ext_rcw && !lock_err && !soft_lock
        && ext_req.wdata[2] && no_set
        |=> !flags.transmit_underrun_flag && !flags.receive_overrun_flag
            && !flags.error_flag)
        else $error("error flags not cleared");

    AST_ITO_KEEP: assert property (
        ce && !core.in_debug && no_set
        |=> flags.instr_transfer_overrun_flag
            == $past(flags.instr_transfer_overrun_flag))
        else $error("instruction overrun flag changed outside debug");

    AST_ZERO_NOP: assert property (
        ext_rcw && ext_req.wdata[3:2] == 2'b00 && !int_req.valid && no_set
        |=> $stable(flags))
        else $error("zero write changed flags");

    AST_LOCK_ERR: assert property (
        ext_rcw && lock_err && !int_req.valid && no_set
        |=> ext_rsp.err && $stable(flags))
        else $error("locked access not refused");

    AST_SET_WINS: assert property (
        ce && flag_set.pipeline_advanced_flag
        |=> flags.pipeline_advanced_flag)
        else $error("set lost against clear");

    // Remaining identification words, answer without request, reserve control read
    AST_PID0: assert property (
        ext_rd && ext_req.addr == `DBGID_OFF_PID0
        |=> ext_rsp.rdata == {24'h00_0000, PART_NUM[7:0]})
        else $error("peripheral id 0 wrong");

    AST_PID1: assert property (
        ext_rd && ext_req.addr == `DBGID_OFF_PID1
        |=> ext_rsp.rdata == {24'h00_0000, DESIGNER_ID[3:0], PART_NUM[11:8]})
        else $error("peripheral id 1 wrong");

    AST_PID3: assert property (
        ext_rd && ext_req.addr == `DBGID_OFF_PID3
        |=> ext_rsp.rdata == {24'h00_0000, MINOR_REV, CUST_MOD})
        else $error("peripheral id 3 wrong");

    AST_ID_NO_ERR: assert property (
        ext_rd && !rc_hit(ext_req.addr)
        |=> ext_rsp.ack && !ext_rsp.err)
        else $error("identification read refused");

    AST_NO_ACK: assert property (
        ce && !ext_req.valid
        |=> !ext_rsp.ack)
        else $error("answer without request");

    AST_RC_RD_ZERO: assert property (
        ext_rd && rc_hit(ext_req.addr)
        |=> ext_rsp.rdata == 32'h0000_0000)
        else $error("write-only register read back data");

    // Memory-mapped side
    AST_INT_RD_ZERO: assert property (
        int_rd
        |=> int_rsp.ack && int_rsp.rdata == 32'h0000_0000)
        else $error("memory-mapped read not zero");

    AST_INT_CLR_PIPE: assert property (
        int_rcw && !lock_err && !soft_lock
        && int_req.wdata[3] && !flag_set.pipeline_advanced_flag
        |=> !flags.pipeline_advanced_flag)
        else $error("memory-mapped clear lost");

    AST_INT_LOCK_ERR: assert property (
        int_rcw && lock_err && !ext_req.valid && no_set
        |=> int_rsp.err && $stable(flags))
        else $error("memory-mapped locked access not refused");

    AST_INT_SOFT_WI: assert property (
        int_rcw && soft_lock && !lock_err && !ext_req.valid && no_set
        |=> !int_rsp.err && $stable(flags))
        else $error("memory-mapped write under soft lock acted");

    // Soft lock, debug-state clear, combined clear and error flag set
    AST_SOFT_WI: assert property (
        ext_rcw && soft_lock && !lock_err && !int_req.valid && no_set
        |=> !ext_rsp.err && $stable(flags))
        else $error("write under soft lock acted");

    AST_ITO_CLR: assert property (
        ext_rcw && !lock_err && !soft_lock && ext_req.wdata[2]
        && core.in_debug && no_set
        |=> !flags.instr_transfer_overrun_flag)
        else $error("instruction overrun flag kept in debug state");

    AST_CLR_BOTH: assert property (
        ext_rcw && !lock_err && !soft_lock
        && ext_req.wdata[3:2] == 2'b11 && no_set
        |=> !flags.pipeline_advanced_flag && !flags.error_flag)
        else $error("combined clear incomplete");

    AST_ERR_SET: assert property (
        ce && flag_set.error_flag
        |=> flags.error_flag)
        else $error("error flag set lost");

    // Clock enable low holds every register
    AST_CE_HOLD: assert property (
        !ce
        |=> $stable(flags) && $stable(ext_rsp) && $stable(int_rsp))
        else $error("state moved with clock enable low");

    COV_CLR_BOTH: cover property (
        ext_rcw && ext_req.wdata[3:2] == 2'b11 && !lock_err && !soft_lock);
    COV_LOCK: cover property (ext_rcw && lock_err);
    COV_SOFT: cover property (ext_rcw && soft_lock && ext_req.wdata[3]);
    COV_ITO: cover property (clr_ito && flags.instr_transfer_overrun_flag);
    COV_INT_CLR: cover property (int_rcw && int_req.wdata[2] && !lock_err && !soft_lock);

endmodule

`default_nettype wire

// File: tb/dbgid_dbg_model.sv
// Purpose: Debugger model issuing single-word accesses on one request port
// Assumes: Each cycle with valid high is one access; answer one cycle later
// Notes:   Released lines carry the inverse of the last request
`timescale 1ns/1ps
`default_nettype none

module dbgid_dbg_model (
    input  wire logic                  clk,
    output var  dbgid_pkg::dbgid_req_t req,
    input  wire dbgid_pkg::dbgid_rsp_t rsp
);
    import dbgid_pkg::*;

    // Idle cycles before each access, slow or prompt debugger
    int unsigned gap = 0;

    initial req = '0;

    // One access: drive for one cycle, then scramble and sample the answer
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err, output logic ack);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        req <= '{valid: 1'b1, write: wr, addr: addr, wdata: wd};
        @(posedge clk);
        req <= '{valid: 1'b0, write: ~wr, addr: ~addr, wdata: ~wd};
        @(negedge clk);
        ack = rsp.ack;
        err = rsp.err;
        rd = rsp.rdata;
    endtask
endmodule

`default_nettype wire

// File: tb/test_debug_ident_and_reserve_control.sv
// Purpose: Self-checking bench for the debug id and reserve control block
// Assumes: Both request ports driven by debugger models on one clock
// Notes:   Random clears, locks and addresses from a fixed seed
`timescale 1ns/1ps
`default_nettype none

module test_debug_ident_and_reserve_control;
    import dbgid_pkg::*;
    localparam logic [11:0] PN = 12'h5a3; // Arbitrary value
    localparam logic [6:0]  DI = 7'h35;   // Arbitrary value
    localparam logic [3:0]  CC = 4'h7;    // Arbitrary value
    localparam logic [3:0]  MJ = 4'h6;    // Arbitrary value
    localparam logic [3:0]  MN = 4'h3;
    localparam logic [3:0]  CM = 4'h9;
    logic         clk = 1'b0, rst = 1'b1, ce = 1'b1;
    dbgid_req_t   ext_req, int_req;
    dbgid_rsp_t   ext_rsp, int_rsp;
    dbgid_core_t  core = '0;
    dbgid_flags_t flag_set = '0, flags, exp_f, sv;
    int           fail_count = 0, samples_checked = 0, cycles = 0;
    logic [31:0]  rd, rd2, wd, wd2, lk;
    logic [11:0]  ea;
    logic         err, err2, ack, ack2, we, wi;

    dbgid_regs #(.PART_NUM(PN), .DESIGNER_ID(DI), .CONT_CODE(CC), .MAJOR_REV(MJ),
        .MINOR_REV(MN), .CUST_MOD(CM)) dbgid_regs_i (.clk(clk), .rst(rst), .ce(ce),
        .ext_req(ext_req), .int_req(int_req), .core(core), .flag_set(flag_set),
        .ext_rsp(ext_rsp), .int_rsp(int_rsp), .flags(flags));
    dbgid_dbg_model dbg_i (.clk(clk), .req(ext_req), .rsp(ext_rsp));
    dbgid_dbg_model sw_i (.clk(clk), .req(int_req), .rsp(int_rsp));

    // Clock and hang limit
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic check_bit(input string what, input logic e, input logic g);
        check_word(what, {31'h0, e}, {31'h0, g});
    endtask

    task automatic check_flags(input string what, input dbgid_flags_t e, input dbgid_flags_t g);
        check_word(what, {27'h0, e}, {27'h0, g});
    endtask

    // Expected read data of the external side
    function automatic logic [31:0] exp_rd(input logic [11:0] a);
        case (a)
            12'hff0: return 32'h0000000d;
            12'hff4: return 32'h00000090;
            12'hff8: return 32'h00000005;
            12'hffc: return 32'h000000b1;
            12'hfe0: return {24'h0, PN[7:0]};
            12'hfe4: return {24'h0, DI[3:0], PN[11:8]};
            12'hfe8: return {24'h0, MJ, 1'b1, DI[6:4]};
            12'hfec: return {24'h0, MN, CM};
            12'hfd0: return {24'h0, 4'h0, CC};
            default: return 32'h0;
        endcase
    endfunction

    function automatic logic exp_err(input logic [11:0] a);
        return a == 12'h090 && (core.powered_off || core.double_lock_state || core.os_lock_state);
    endfunction

    // Flags after one access
    function automatic dbgid_flags_t exp_clr(input dbgid_flags_t f, input logic wr,
                                             input logic [11:0] a, input logic [31:0] w);
        if (!wr || exp_err(a) || a != 12'h090 || core.software_lock_state) return f;
        if (w[3]) f.pipeline_advanced_flag = 1'b0;
        if (w[2]) begin
            f.transmit_underrun_flag = 1'b0;
            f.receive_overrun_flag = 1'b0;
            f.error_flag = 1'b0;
            if (core.in_debug) f.instr_transfer_overrun_flag = 1'b0;
        end
        return f;
    endfunction

    initial begin
        void'($urandom(54));
        repeat (10) @(posedge clk);
        check_flags("reset flags", '0, flags);
        check_bit("reset ack", 1'b0, ext_rsp.ack);
        rst <= 1'b0;
        // Every word of the id page, then random words, on both ports, each after its own random gap of 0 to 2 cycles
        for (int i = 0; i < 30; i++) begin
            ea = (i < 16) ? 12'hfc0 + 12'(i * 4) : (i == 16) ? 12'h090 : 12'(($urandom % 1024) * 4);
            dbg_i.gap = $urandom % 3;
            sw_i.gap = $urandom % 3;
            fork
                dbg_i.xfer(1'b0, ea, $urandom, rd, err, ack);
                sw_i.xfer(1'b0, ea, $urandom, rd2, err2, ack2);
            join
            check_bit("ext ack", 1'b1, ack);
            check_word("ext rdata", exp_rd(ea), rd);
            check_bit("ext err", 1'b0, err);
            check_word("int rdata", 32'h0, rd2);
        end
        // Random sets, locks and clears from both ports, each after the idle gap left from the id page loop
        exp_f = '0;
        for (int n = 0; n < 80; n++) begin
            lk = $urandom;
            sv = lk[17:13];
            @(posedge clk);
            flag_set <= sv;
            core <= {lk[2:0] == 0, lk[5:3] == 0, lk[8:6] == 0, lk[11:9] == 0, lk[12]};
            @(posedge clk);
            flag_set <= '0;
            exp_f = exp_f | sv;
            ea = ($urandom % 4 == 0) ? 12'(($urandom % 1024) * 4) : 12'h090;
            we = $urandom % 4 != 0;
            wi = $urandom % 4 != 0;
            wd = $urandom;
            wd2 = $urandom;
            fork
                dbg_i.xfer(we, ea, wd, rd, err, ack);
                sw_i.xfer(wi, 12'h090, wd2, rd2, err2, ack2);
            join
            exp_f = exp_clr(exp_clr(exp_f, we, ea, wd), wi, 12'h090, wd2);
            check_flags("flags", exp_f, flags);
            check_bit("ext err", exp_err(ea), err);
            check_bit("int err", exp_err(12'h090), err2);
            check_bit("int ack", 1'b1, ack2);
            check_bit("ext ack", 1'b1, ack);
            check_word("ext rdata", we ? 32'h0 : exp_rd(ea), rd);
            check_word("int rdata", 32'h0, rd2);
        end
        // Mid-run reset wipes set flags; first read right after release
        @(posedge clk);
        flag_set <= '1;
        @(posedge clk);
        flag_set <= '0;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        check_flags("mid reset flags", '0, flags);
        rst <= 1'b0;
        exp_f = '0;
        dbg_i.gap = 0;
        dbg_i.xfer(1'b0, 12'hff0, $urandom, rd, err, ack);
        check_bit("ack after reset", 1'b1, ack);
        check_word("rdata after reset", 32'h0000000d, rd);
        // Clock enable low freezes the flags
        @(posedge clk);
        ce <= 1'b0;
        flag_set <= '1;
        repeat (2) @(posedge clk);
        check_flags("frozen flags", exp_f, flags);
        ce <= 1'b1;
        flag_set <= '0;
        print_verdict();
    end
endmodule

`default_nettype wire
